// file: hw/tfs_defs.vh
// constants for the transmitter fault sequencer
`ifndef TFS_DEFS_VH
`define TFS_DEFS_VH

// timing
`define TFS_CLK_NS        10
`define TFS_TICK_NS       1000000
`define TFS_TICK_CYCLES   (`TFS_TICK_NS / `TFS_CLK_NS)
`define TFS_TICK_MS       1
`define TFS_RECYCLE_MS    1000
`define TFS_WATCH_MS      2400
`define TFS_UDGATE_MS     300
`define TFS_FILT_MS       4
`define TFS_RECYCLE_TICKS (`TFS_RECYCLE_MS / `TFS_TICK_MS)
`define TFS_WATCH_TICKS   (`TFS_WATCH_MS / `TFS_TICK_MS)
`define TFS_UDGATE_TICKS  (`TFS_UDGATE_MS / `TFS_TICK_MS)
`define TFS_FILT_TICKS    (`TFS_FILT_MS / `TFS_TICK_MS)

// register map
`define TFS_REG_CTRL      4'h0
`define TFS_REG_STATUS    4'h4
`define TFS_CTRL_MRST_BIT 0
`define TFS_RESP_OKAY     2'b00
`define TFS_RESP_SLVERR   2'b10

// status field positions
`define TFS_ST_ALARM_LSB  0
`define TFS_ST_INTLK_LSB  4
`define TFS_ST_TRIP_LSB   6
`define TFS_ST_ACT_LSB    9
`define TFS_ST_OVL_BIT    12
`define TFS_ST_UDG_BIT    13
`define TFS_ST_SHUT_BIT   14
`define TFS_ST_PAOFF_BIT  15

`endif

// file: hw/tfs_sequencer.v
// fault supervision: supply alarms, interlock lamps, recycle sequencer
`timescale 1ns/10ps
`default_nettype none
`include "tfs_defs.vh"

// Contract
// - each supply alarm input is active low and raises a shutdown fault
// - output monitor +5 and -5 regulators have separate alarm inputs
// - positive rail alarm pulled low by regulator board causes shutdown fault
// - supply alarms are filtered so brief pulses cause no shutdown
// - two identical interlock channels: door and external
// - interlock high: green on, red off, external fault output low
// - interlock low: green off, red on, external fault output high
// - overdrive, underdrive and current overload each run their own identical recycle sequence
// - recycle fault immediately requests power amplifier supply off
// - after one second release power-off and start the watch timer
// - repeat within the 2.4 second watch raises a shutdown fault
// - no repeat in the watch: indication and operation return to normal
// - any recycle fault latches overload indicator red until manual reset
// - overdrive detector output is active high
// - underdrive detector blocked while the gate release is low
// - gate release rises 0.3 seconds after contactor closed rises
// - each contactor closed rising edge restarts the underdrive ramp
// - first underdrive shows amber and recycles; repeat turns off, red
// - recycle timer starts only on a rising detector edge
// - both indicator sections are off during the watch window
module tfs_sequencer #(
	parameter TICK_CYCLES = `TFS_TICK_CYCLES,
	parameter RECYCLE_T   = `TFS_RECYCLE_TICKS,
	parameter WATCH_T     = `TFS_WATCH_TICKS,
	parameter UDGATE_T    = `TFS_UDGATE_TICKS,
	parameter FILT_T      = `TFS_FILT_TICKS
) (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        om_p5_alarm_n,
	input  wire        om_n5_alarm_n,
	input  wire        dcr_bplus_alarm_n,
	input  wire        dcr_bminus_alarm_n,
	input  wire        door_intlk_ok,
	input  wire        ext_intlk_ok,
	input  wire        overdrive_det,
	input  wire        underdrive_det,
	input  wire        current_ovl_det,
	input  wire        step_start_contactor,
	output reg         shutdown_fault,
	output reg         pa_off_req,
	output reg         ud_gate_release,
	output reg         ud_ramp_restart,
	output reg  [1:0]  intlk_led_grn,
	output reg  [1:0]  intlk_led_red,
	output reg  [1:0]  intlk_ext_fault,
	output reg  [2:0]  rec_led_grn,
	output reg  [2:0]  rec_led_red,
	output reg  [2:0]  rec_ext_fault,
	output reg         ovl_led_red,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	localparam ST_IDLE  = 4'b0001;
	localparam ST_OFF   = 4'b0010;
	localparam ST_WATCH = 4'b0100;
	localparam ST_TRIP  = 4'b1000;

	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	wire [9:0] raw_in;
	reg  [9:0] sync1_r;
	reg  [9:0] sync2_r;
	reg  [9:0] prev_r;

	assign raw_in = {step_start_contactor, current_ovl_det, underdrive_det,
		overdrive_det, ext_intlk_ok, door_intlk_ok, dcr_bminus_alarm_n,
		dcr_bplus_alarm_n, om_n5_alarm_n, om_p5_alarm_n};

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_r <= 10'h03f;
			sync2_r <= 10'h03f;
			prev_r  <= 10'h03f;
		end
		else
		begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// ----------------------------------------------------------------
	// timebase tick
	// ----------------------------------------------------------------
	reg [31:0] tick_cnt_r;
	reg        tick_r;

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_r <= 32'h0;
			tick_r     <= 1'b0;
		end
		else if (tick_cnt_r >= TICK_CYCLES - 1)
		begin
			tick_cnt_r <= 32'h0;
			tick_r     <= 1'b1;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
			tick_r     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// supply alarm filters
	// ----------------------------------------------------------------
	wire [3:0] alarm_filt;
	wire       man_rst;
	genvar     gi;

	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_alarm
			reg [15:0] cnt_r;
			reg        flt_r;
			always @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					cnt_r <= 16'h0;
					flt_r <= 1'b0;
				end
				else if (sync2_r[gi])
				begin
					cnt_r <= 16'h0;
					flt_r <= 1'b0;
				end
				else if (cnt_r >= FILT_T)
					flt_r <= 1'b1;
				else if (tick_r)
					cnt_r <= cnt_r + 16'h1;
			end
			assign alarm_filt[gi] = flt_r;
		end
	endgenerate

	// ----------------------------------------------------------------
	// underdrive gate and ramp restart
	// ----------------------------------------------------------------
	reg [15:0] ud_cnt_r;
	reg        ud_gate_d_r;
	wire       con_rise;

	assign con_rise = sync2_r[9] & ~prev_r[9];

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ud_cnt_r        <= 16'h0;
			ud_gate_release <= 1'b0;
			ud_ramp_restart <= 1'b0;
			ud_gate_d_r     <= 1'b0;
		end
		else
		begin
			ud_ramp_restart <= con_rise;
			ud_gate_d_r     <= ud_gate_release;
			if (!sync2_r[9] || con_rise)
			begin
				ud_cnt_r        <= 16'h0;
				ud_gate_release <= 1'b0;
			end
			else if (ud_cnt_r >= UDGATE_T)
				ud_gate_release <= 1'b1;
			else if (tick_r)
				ud_cnt_r <= ud_cnt_r + 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// recycle sequencers: 0 overdrive, 1 underdrive, 2 current
	// ----------------------------------------------------------------
	wire [2:0] det_now;
	wire [2:0] det_old;
	wire [2:0] rec_off;
	wire [2:0] rec_trip;
	wire [2:0] rec_act;

	assign det_now = {sync2_r[8], sync2_r[7] & ud_gate_release,
		sync2_r[6]};
	assign det_old = {prev_r[8], prev_r[7] & ud_gate_d_r, prev_r[6]};

	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_rec
			reg [3:0]  st_r;
			reg [15:0] cnt_r;
			wire       rise;
			assign rise = det_now[gi] & ~det_old[gi];
			always @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					st_r  <= ST_IDLE;
					cnt_r <= 16'h0;
				end
				else
				begin
					case (st_r)
						ST_IDLE:
						begin
							cnt_r <= 16'h0;
							if (rise)
								st_r <= ST_OFF;
						end
						ST_OFF:
						begin
							if (cnt_r >= RECYCLE_T)
							begin
								cnt_r <= 16'h0;
								st_r  <= ST_WATCH;
							end
							else if (tick_r)
								cnt_r <= cnt_r + 16'h1;
						end
						ST_WATCH:
						begin
							if (rise)
								st_r <= ST_TRIP;
							else if (cnt_r >= WATCH_T)
								st_r <= ST_IDLE;
							else if (tick_r)
								cnt_r <= cnt_r + 16'h1;
						end
						ST_TRIP:
						begin
							if (man_rst)
								st_r <= ST_IDLE;
						end
						default:
							st_r <= ST_IDLE;
					endcase
				end
			end
			assign rec_off[gi]  = st_r[1];
			assign rec_trip[gi] = st_r[3];
			assign rec_act[gi]  = ~st_r[0];
		end
	endgenerate

	// ----------------------------------------------------------------
	// indicators and controller requests
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shutdown_fault  <= 1'b0;
			pa_off_req      <= 1'b0;
			intlk_led_grn   <= 2'b00;
			intlk_led_red   <= 2'b00;
			intlk_ext_fault <= 2'b00;
			rec_led_grn     <= 3'b000;
			rec_led_red     <= 3'b000;
			rec_ext_fault   <= 3'b000;
			ovl_led_red     <= 1'b0;
		end
		else
		begin
			shutdown_fault  <= (|alarm_filt) | (|rec_trip);
			pa_off_req      <= |rec_off;
			intlk_led_grn   <= sync2_r[5:4];
			intlk_led_red   <= ~sync2_r[5:4];
			intlk_ext_fault <= ~sync2_r[5:4];
			// amber while off, dark in the watch, red once tripped
			rec_led_grn     <= ~rec_act | rec_off;
			rec_led_red     <= rec_off | rec_trip;
			rec_ext_fault   <= rec_trip;
			if (|rec_off)
				ovl_led_red <= 1'b1;
			else if (man_rst)
				ovl_led_red <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite register slave
	// ----------------------------------------------------------------
	reg        aw_hold_r;
	reg        w_hold_r;
	reg        man_rst_r;
	reg [3:0]  awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0]  wstrb_r;
	wire       aw_take;
	wire       w_take;
	wire       ar_take;
	wire       commit;
	wire       aw_hold_nxt;
	wire       w_hold_nxt;
	wire       bvalid_nxt;
	wire       rvalid_nxt;
	wire [31:0] status;

	function reg_hit;
		input [3:0] addr;
		reg_hit = (addr == `TFS_REG_CTRL) || (addr == `TFS_REG_STATUS);
	endfunction

	assign aw_take     = s_axi_awvalid & s_axi_awready;
	assign w_take      = s_axi_wvalid & s_axi_wready;
	assign ar_take     = s_axi_arvalid & s_axi_arready;
	assign commit      = aw_hold_r & w_hold_r & ~s_axi_bvalid;
	assign aw_hold_nxt = (aw_hold_r | aw_take) & ~commit;
	assign w_hold_nxt  = (w_hold_r | w_take) & ~commit;
	assign bvalid_nxt  = commit | (s_axi_bvalid & ~s_axi_bready);
	assign rvalid_nxt  = ar_take | (s_axi_rvalid & ~s_axi_rready);
	assign man_rst     = man_rst_r;

	assign status = {16'h0, pa_off_req, shutdown_fault, ud_gate_release,
		ovl_led_red, rec_act, rec_trip, ~sync2_r[5:4], alarm_filt};

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			man_rst_r     <= 1'b0;
			awaddr_r      <= 4'h0;
			wdata_r       <= 32'h0;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'b00;
		end
		else
		begin
			aw_hold_r     <= aw_hold_nxt;
			w_hold_r      <= w_hold_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt;
			s_axi_wready  <= ~w_hold_nxt & ~bvalid_nxt;
			s_axi_arready <= ~rvalid_nxt;
			man_rst_r     <= commit & (awaddr_r == `TFS_REG_CTRL) &
				wstrb_r[0] & wdata_r[`TFS_CTRL_MRST_BIT];
			if (aw_take)
				awaddr_r <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (commit)
				s_axi_bresp <= reg_hit(awaddr_r) ? `TFS_RESP_OKAY :
					`TFS_RESP_SLVERR;
			if (ar_take)
			begin
				s_axi_rdata <= (s_axi_araddr == `TFS_REG_STATUS) ?
					status : 32'h0;
				s_axi_rresp <= reg_hit(s_axi_araddr) ? `TFS_RESP_OKAY :
					`TFS_RESP_SLVERR;
			end
		end
	end

endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking testbench for the transmitter fault sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  alm_n = 4'hf;
	logic [1:0]  ilk = 2'h3;
	logic        od = 1'b0, ud = 1'b0, co = 1'b0, run = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire logic   s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic   ssc, shutdown_fault, pa_off_req, ud_gate_release, urr;
	wire logic   ovl_led_red;
	wire logic [1:0] ig, ir, ie;
	wire logic [2:0] rg, rr, re;
	int          num_errors = 0, checks_done = 0, i, n;
	logic        seen;
	logic [6:0]  rows [6] = '{7'h7e, 7'h75, 7'h6b, 7'h59, 7'h3f, 7'h7e};
	always #5 mclk = ~mclk;
	tfs_sequencer #(.TICK_CYCLES(10), .RECYCLE_T(5), .WATCH_T(8),
		.UDGATE_T(3), .FILT_T(2)) u_tfs_sequencer (.mclk, .rst_n,
		.om_p5_alarm_n(alm_n[0]), .om_n5_alarm_n(alm_n[1]),
		.dcr_bplus_alarm_n(alm_n[2]), .dcr_bminus_alarm_n(alm_n[3]),
		.door_intlk_ok(ilk[0]), .ext_intlk_ok(ilk[1]),
		.overdrive_det(od), .underdrive_det(ud), .current_ovl_det(co),
		.step_start_contactor(ssc), .shutdown_fault, .pa_off_req,
		.ud_gate_release, .ud_ramp_restart(urr), .intlk_led_grn(ig),
		.intlk_led_red(ir), .intlk_ext_fault(ie), .rec_led_grn(rg),
		.rec_led_red(rr), .rec_ext_fault(re), .ovl_led_red,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	tfs_ctrl_model u_tfs_ctrl_model (.mclk, .rst_n, .run,
		.shutdown_fault, .step_start_contactor(ssc));
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tmo;
		num_errors++;
		test_done();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic wfall(output int k);
		for (k = 0; k < 200 && pa_off_req !== 1'b0; k++)
			@(posedge mclk);
		if (k == 200)
			tmo();
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int k;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++)
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (k == 50)
			tmo();
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		int k;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++)
		begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (k == 50)
			tmo();
		chk(s_axi_rdata & m, e);
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	// --------
	// main sequence
	// --------
	initial
	begin
		cyc(12);
		rst_n <= 1'b1;
		cyc(4);
		chk(32'({pa_off_req, shutdown_fault, ovl_led_red, rg}), 32'h7);
		rdchk(4'h0, 32'hffffffff, 32'h0, 2'h0);
		rdchk(4'h8, 32'hffffffff, 32'h0, 2'h2);
		axw(4'hc, 32'h1, 2'h2);
		axw(4'h4, 32'h0, 2'h0);
		$display("test registers finished");
		for (i = 0; i < 6; i++)
		begin
			{alm_n, ilk} <= rows[i][6:1];
			cyc(60);
			chk(32'({ig, ir, ie}), 32'({rows[i][2:1], ~rows[i][2:1],
				~rows[i][2:1]}));
			chk(32'(shutdown_fault), 32'(rows[i][0]));
		end
		$display("test table finished");
		alm_n <= 4'he;
		cyc(5);
		alm_n <= 4'hf;
		cyc(40);
		chk(32'(shutdown_fault), 32'h0);
		$display("test glitch finished");
		od <= 1'b1;
		cyc(8);
		chk(32'({pa_off_req, rg, rr}), 32'h79);
		wfall(n);
		chk(32'(n >= 30 && n <= 55), 32'h1);
		cyc(3);
		chk(32'({rg, rr}), 32'h30);
		cyc(100);
		chk(32'({pa_off_req, shutdown_fault, re, rg, rr}), 32'h38);
		rdchk(4'h4, 32'h1000, 32'h1000, 2'h0);
		axw(4'h0, 32'h1, 2'h0);
		cyc(3);
		chk(32'(ovl_led_red), 32'h0);
		od <= 1'b0;
		$display("test recycle finished");
		co <= 1'b1;
		cyc(8);
		wfall(n);
		co <= 1'b0;
		cyc(5);
		co <= 1'b1;
		cyc(10);
		chk(32'({shutdown_fault, re, rg, rr}), 32'h31c);
		co <= 1'b0;
		axw(4'h0, 32'h1, 2'h0);
		cyc(5);
		chk(32'({shutdown_fault, re}), 32'h0);
		$display("test repeat finished");
		ud <= 1'b1;
		cyc(20);
		chk(32'(pa_off_req), 32'h0);
		run <= 1'b1;
		seen = 1'b0;
		for (n = 0; n < 100 && ud_gate_release !== 1'b1; n++)
		begin
			@(posedge mclk);
			seen = seen | urr;
		end
		chk(32'(n >= 25 && n <= 50), 32'h1);
		chk(32'(seen), 32'h1);
		ud <= 1'b1;
		cyc(8);
		chk(32'({rg, rr}), 32'h3a);
		wfall(n);
		ud <= 1'b0;
		cyc(5);
		ud <= 1'b1;
		cyc(10);
		chk(32'({shutdown_fault, rg, rr}), 32'h6a);
		cyc(5);
		chk(32'(ud_gate_release), 32'h0);
		ud <= 1'b0;
		run <= 1'b0;
		axw(4'h0, 32'h1, 2'h0);
		$display("test underdrive finished");
		rst_n <= 1'b0;
		cyc(2);
		chk(32'({pa_off_req, shutdown_fault, ovl_led_red, rg, rr}), 32'h0);
		rst_n <= 1'b1;
		cyc(4);
		chk(32'(rg), 32'h7);
		$display("test reset finished");
		test_done();
	end
endmodule
bind tfs_sequencer tfs_seq_chk #(.TICK_CYCLES(TICK_CYCLES),
	.RECYCLE_T(RECYCLE_T), .UDGATE_T(UDGATE_T), .FILT_T(FILT_T))
	u_tfs_seq_chk (.mclk, .rst_n, .om_p5_alarm_n, .om_n5_alarm_n,
	.dcr_bplus_alarm_n, .dcr_bminus_alarm_n, .door_intlk_ok,
	.ext_intlk_ok, .step_start_contactor, .shutdown_fault, .pa_off_req,
	.ud_gate_release, .ud_ramp_restart, .intlk_led_grn, .intlk_led_red,
	.intlk_ext_fault, .rec_led_grn, .rec_led_red, .rec_ext_fault);
`default_nettype wire

// file: tb/tfs_ctrl_model.sv
// controller turn-on logic model driving the contactor line
`timescale 1ns/10ps
`default_nettype none
module tfs_ctrl_model #(
	parameter CLOSE_DLY = 3
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic run,
	input  wire logic shutdown_fault,
	output var  logic step_start_contactor
);
	int dly_r;
	// closes some cycles after run with no fault, opens at once on shutdown
	always @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			dly_r <= 0;
			step_start_contactor <= 1'b0;
		end
		else if (!run || shutdown_fault)
		begin
			dly_r <= 0;
			step_start_contactor <= 1'b0;
		end
		else
		begin
			if (dly_r < CLOSE_DLY)
				dly_r <= dly_r + 1;
			step_start_contactor <= (dly_r >= CLOSE_DLY);
		end
endmodule
`default_nettype wire

// file: tb/tfs_sequencer_properties.sv
// assertion checker for the transmitter fault sequencer
`timescale 1ns/10ps
`default_nettype none
module tfs_seq_chk #(
	parameter TICK_CYCLES = 10,
	parameter RECYCLE_T   = 1000,
	parameter UDGATE_T    = 300,
	parameter FILT_T      = 4
) (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       om_p5_alarm_n,
	input wire logic       om_n5_alarm_n,
	input wire logic       dcr_bplus_alarm_n,
	input wire logic       dcr_bminus_alarm_n,
	input wire logic       door_intlk_ok,
	input wire logic       ext_intlk_ok,
	input wire logic       step_start_contactor,
	input wire logic       shutdown_fault,
	input wire logic       pa_off_req,
	input wire logic       ud_gate_release,
	input wire logic       ud_ramp_restart,
	input wire logic [1:0] intlk_led_grn,
	input wire logic [1:0] intlk_led_red,
	input wire logic [1:0] intlk_ext_fault,
	input wire logic [2:0] rec_led_grn,
	input wire logic [2:0] rec_led_red,
	input wire logic [2:0] rec_ext_fault
);
	localparam int RMIN = (RECYCLE_T - 1) * TICK_CYCLES;
	localparam int RMAX = (RECYCLE_T + 1) * TICK_CYCLES;
	localparam int GMIN = (UDGATE_T - 1) * TICK_CYCLES;
	localparam int GMAX = (UDGATE_T + 1) * TICK_CYCLES + 6;
	localparam int AMAX = (FILT_T + 2) * TICK_CYCLES + 6;
	wire logic [3:0] alm = {om_p5_alarm_n, om_n5_alarm_n,
		dcr_bplus_alarm_n, dcr_bminus_alarm_n};
	int pa_cnt_r;
	int ct_cnt_r;
	int al_cnt_r;
	// --------
	// run lengths of off request, closed contactor and steady alarm
	// --------
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			pa_cnt_r <= 0;
			ct_cnt_r <= 0;
			al_cnt_r <= 0;
		end
		else
		begin
			pa_cnt_r <= pa_off_req ? pa_cnt_r + 1 : 0;
			ct_cnt_r <= step_start_contactor ? ct_cnt_r + 1 : 0;
			al_cnt_r <= (alm != 4'hf && $stable(alm)) ? al_cnt_r + 1 : 0;
		end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	property p_door_ok;
		door_intlk_ok [*5] |-> intlk_led_grn[0] && !intlk_led_red[0]
			&& !intlk_ext_fault[0];
	endproperty
	a_door_ok: assert property (p_door_ok)
		else $error("door lamp wrong while closed");
	property p_ext_bad;
		!ext_intlk_ok [*5] |-> !intlk_led_grn[1] && intlk_led_red[1]
			&& intlk_ext_fault[1];
	endproperty
	a_ext_bad: assert property (p_ext_bad)
		else $error("external lamp wrong while open");
	property p_amber;
		pa_off_req |-> (rec_led_grn & rec_led_red) != 3'h0;
	endproperty
	a_amber: assert property (p_amber)
		else $error("off request without amber lamp");
	property p_off_len;
		$fell(pa_off_req) && $past(rst_n) |-> pa_cnt_r >= RMIN
			&& pa_cnt_r <= RMAX;
	endproperty
	a_off_len: assert property (p_off_len)
		else $error("off request length wrong");
	property p_trip;
		rec_ext_fault != 3'h0 ##1 rec_ext_fault != 3'h0 |-> shutdown_fault;
	endproperty
	a_trip: assert property (p_trip)
		else $error("trip without shutdown");
	property p_gate;
		$rose(ud_gate_release) |-> ct_cnt_r >= GMIN && ct_cnt_r <= GMAX;
	endproperty
	a_gate: assert property (p_gate)
		else $error("gate release delay wrong");
	property p_ramp;
		$rose(step_start_contactor) |-> ##[2:5] ud_ramp_restart
			##1 !ud_ramp_restart;
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("ramp restart pulse missing");
	property p_alarm;
		al_cnt_r >= AMAX |-> shutdown_fault;
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("held supply alarm without shutdown");
	c_recycle: cover property ($rose(pa_off_req));
	c_trip: cover property ($rose(rec_ext_fault != 3'h0));
	c_gate: cover property ($rose(ud_gate_release));
endmodule
`default_nettype wire
